/* File: design/ctiu_pkg.sv */
// register map, field positions and reset values of the tx port interrupt unit
// assumes an 8-bit register access port fed by the device's serial control slave
package ctiu_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned EVT_W   = 5;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] PORT_STATUS_OFS   = 8'h35;
  localparam logic [7:0] IRQ_ENABLE_OFS    = 8'h36;
  localparam logic [7:0] IRQ_STATUS_OFS    = 8'h37;
  localparam logic [7:0] RSVD_SLOT_A_OFS   = 8'h38;
  localparam logic [7:0] RSVD_SLOT_B_OFS   = 8'h39;
  localparam logic [7:0] RSVD_SLOT_C_OFS   = 8'h3A;
  localparam logic [7:0] RSVD_RANGE_D_LO   = 8'h3B;
  localparam logic [7:0] RSVD_RANGE_D_HI   = 8'h3F;

  // ==========================================================================
  // enable and flag bit positions (same layout in both registers)
  localparam int unsigned PASS_ASSERT_BIT = 0;
  localparam int unsigned PASS_ERROR_BIT  = 1;
  localparam int unsigned SYNC_ASSERT_BIT = 2;
  localparam int unsigned SYNC_ERROR_BIT  = 3;
  localparam int unsigned RX_PORT_BIT     = 4;

  // port status register fields
  localparam int unsigned STS_PASS_BIT    = 0;
  localparam int unsigned STS_SYNC_BIT    = 1;
  localparam int unsigned STS_PORTNUM_BIT = 4;

  // ==========================================================================
  // reset values
  localparam logic [4:0] IRQ_ENABLE_RST  = 5'h00;
  localparam logic [4:0] IRQ_STATUS_RST  = 5'h00;
  localparam logic [7:0] RSVD_READ_VAL   = 8'h00;

endpackage : ctiu_pkg

/* File: design/ctiu_channel.sv */
// per tx port enable and sticky flag set with its interrupt request
// assumes event pulses and live levels synchronous to sys_clk
`timescale 1ns/1ns

module ctiu_channel
  import ctiu_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // register side
  input  wire logic                   en_wr,
  input  wire logic [EVT_W-1:0]       en_wdata,
  input  wire logic                   flag_rd_clr,
  // event side
  input  wire logic                   rx_irq_evt,
  input  wire logic                   rx_irq_clr,
  input  wire logic                   sync_err_evt,
  input  wire logic                   sync_level,
  input  wire logic                   pass_level,
  input  wire logic                   pass_err_evt,
  // results
  output logic      [EVT_W-1:0]       enable_ff,
  output logic      [EVT_W-1:0]       flags_ff,
  output logic                        irq_ff
);

  // ==========================================================================
  // state
  logic             sync_prev_ff;
  logic             pass_prev_ff;
  logic [EVT_W-1:0] nxt_enable;
  logic [EVT_W-1:0] nxt_flags;
  logic [EVT_W-1:0] set_vec;
  logic [EVT_W-1:0] clr_vec;
  logic             nxt_irq;

  // ==========================================================================
  // next values
  always_comb begin
    nxt_enable = en_wr ? en_wdata : enable_ff;                      // (RQ1) (RQ2) (RQ11)
    set_vec = '0;
    set_vec[RX_PORT_BIT]     = rx_irq_evt;                          // (RQ4)
    set_vec[SYNC_ERROR_BIT]  = sync_err_evt;                        // (RQ5)
    set_vec[SYNC_ASSERT_BIT] = sync_level & ~sync_prev_ff;          // (RQ6)
    set_vec[PASS_ERROR_BIT]  = pass_err_evt;                        // (RQ7)
    set_vec[PASS_ASSERT_BIT] = pass_level & ~pass_prev_ff;          // (RQ8)
    // bit 4 follows the rx port status reads, not this register's read
    clr_vec = {EVT_W{flag_rd_clr}};
    clr_vec[RX_PORT_BIT] = rx_irq_clr;                              // (RQ4)
    // set beats clear so a coincident event survives the read
    nxt_flags = (flags_ff & ~clr_vec) | set_vec;                    // (RQ14)
    nxt_irq   = |(nxt_flags & nxt_enable);                          // (RQ13)
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_ff    <= IRQ_ENABLE_RST;
      flags_ff     <= IRQ_STATUS_RST;
      irq_ff       <= 1'b0;
      sync_prev_ff <= 1'b0;
      pass_prev_ff <= 1'b0;
    end else begin
      enable_ff    <= nxt_enable;
      flags_ff     <= nxt_flags;
      irq_ff       <= nxt_irq;
      sync_prev_ff <= sync_level;
      pass_prev_ff <= pass_level;
    end
  end

endmodule : ctiu_channel

/* File: design/ctiu_top.sv */
// tx port interrupt unit: enable, sticky status and live port status per tx port
// assumes a one-cycle register access port from the serial control slave and
// an externally held port select value choosing the tx port copy
//
// Notes on behaviour
// (RQ1) enable bit 1 lets a pass error event raise the interrupt and resets to 0.
// (RQ2) enable bit 0 lets a pass assertion event raise the interrupt and resets to 0.
// (RQ3) the port select value picks which tx port copy a read or write reaches.
// (RQ4) status bit 4 sets on a forwarded rx port interrupt and clears on the rx status read.
// (RQ5) status bit 3 sets on a sync error, clears on read, resets to 0.
// (RQ6) status bit 2 sets when the port becomes synchronized and clears on read.
// (RQ7) status bit 1 sets when pass drops on a forwarded rx port and clears on read.
// (RQ8) status bit 0 sets when the tx port asserts pass and clears on read.
// (RQ9) slots 0x38 and 0x39 read as zero and do nothing.
// (RQ10) slots 0x3A to 0x3F read as zero and ignore writes.
// (RQ11) enable bits 4, 3 and 2 gate the rx port, sync error and sync assert events.
// (RQ12) port status bit 1 is the live sync level, forced to 0 while sync is disabled.
// (RQ13) the interrupt request stands while any flag is set with its enable.
// (RQ14) bits 7 to 5 read as zero and an event coinciding with a clearing read stays set.
`timescale 1ns/1ns

module ctiu_top
  import ctiu_pkg::*;
#(
  parameter int unsigned NUM_TX = 2
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // register access
  input  wire logic [ctiu_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic [ctiu_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                port_select,
  // per tx port events and levels
  input  wire logic [NUM_TX-1:0]         rx_irq_evt,
  input  wire logic [NUM_TX-1:0]         rx_irq_clr,
  input  wire logic [NUM_TX-1:0]         sync_err_evt,
  input  wire logic [NUM_TX-1:0]         sync_level,
  input  wire logic [NUM_TX-1:0]         sync_disable,
  input  wire logic [NUM_TX-1:0]         pass_level,
  input  wire logic [NUM_TX-1:0]         pass_err_evt,
  // results
  output logic      [ctiu_pkg::DATA_W-1:0] rd_data_ff,
  output logic                           rd_valid_ff,
  output logic      [NUM_TX-1:0]         tx_irq_ff
);

  import ctiu_pkg::*;

  // ==========================================================================
  // decode helpers
  localparam int unsigned SEL_W = (NUM_TX > 1) ? $clog2(NUM_TX) : 1;

  // any reserved slot of this range reads zero and ignores writes
  function automatic logic is_reserved(input logic [ADDR_W-1:0] a);
    is_reserved = (a == RSVD_SLOT_A_OFS) || (a == RSVD_SLOT_B_OFS) ||    // (RQ9)
                  (a == RSVD_SLOT_C_OFS) ||
                  ((a >= RSVD_RANGE_D_LO) && (a <= RSVD_RANGE_D_HI));   // (RQ10)
  endfunction : is_reserved

  // ==========================================================================
  // port selection
  logic [SEL_W-1:0] sel;
  logic             sel_ok;

  assign sel    = port_select[SEL_W-1:0];
  assign sel_ok = ({24'h0000_00, port_select} < 32'(NUM_TX));

  // ==========================================================================
  // per port channels
  logic [EVT_W-1:0] enable_q [NUM_TX];
  logic [EVT_W-1:0] flags_q  [NUM_TX];
  logic [NUM_TX-1:0] sync_eff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TX; gi++) begin : g_port
      logic hit;

      // only the selected copy sees the access
      assign hit = sel_ok && (sel == SEL_W'(gi));                      // (RQ3)

      // sync is not reported while forwarding has it turned off
      assign sync_eff[gi] = sync_level[gi] & ~sync_disable[gi];        // (RQ12)

      ctiu_channel u_channel (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .en_wr        (hit && reg_wr && (reg_addr == IRQ_ENABLE_OFS)),
        .en_wdata     (reg_wdata[EVT_W-1:0]),
        .flag_rd_clr  (hit && reg_rd && (reg_addr == IRQ_STATUS_OFS)),
        .rx_irq_evt   (rx_irq_evt[gi]),
        .rx_irq_clr   (rx_irq_clr[gi]),
        .sync_err_evt (sync_err_evt[gi]),
        .sync_level   (sync_eff[gi]),
        .pass_level   (pass_level[gi]),
        .pass_err_evt (pass_err_evt[gi]),
        .enable_ff    (enable_q[gi]),
        .flags_ff     (flags_q[gi]),
        .irq_ff       (tx_irq_ff[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // read path
  logic [DATA_W-1:0] nxt_rd_data;
  logic              nxt_rd_valid;

  always_comb begin
    nxt_rd_data  = '0;
    nxt_rd_valid = reg_rd;
    if (reg_rd && sel_ok) begin
      if (reg_addr == IRQ_ENABLE_OFS) begin
        nxt_rd_data = {3'b000, enable_q[sel]};                         // (RQ14)
      end else if (reg_addr == IRQ_STATUS_OFS) begin
        // flags as they stood before the clearing read
        nxt_rd_data = {3'b000, flags_q[sel]};                          // (RQ14)
      end else if (reg_addr == PORT_STATUS_OFS) begin
        nxt_rd_data[STS_SYNC_BIT]    = sync_eff[sel];                  // (RQ12)
        nxt_rd_data[STS_PASS_BIT]    = pass_level[sel];
        nxt_rd_data[STS_PORTNUM_BIT] = sel[0];
      end else if (is_reserved(reg_addr)) begin
        nxt_rd_data = RSVD_READ_VAL;                                   // (RQ9) (RQ10)
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

endmodule : ctiu_top

/* File: dv/ctiu_sva.sv */
// checker for the tx port interrupt unit, watching tx port 0
// assumes port 0 levels are held low while status is being cleared
`timescale 1ns/1ns
module ctiu_sva #(
  parameter int unsigned NUM_TX = 2
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // register access
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_rd,
  input wire logic [7:0]        port_select,
  // events and levels
  input wire logic [NUM_TX-1:0] rx_irq_evt,
  input wire logic [NUM_TX-1:0] rx_irq_clr,
  input wire logic [NUM_TX-1:0] sync_err_evt,
  input wire logic [NUM_TX-1:0] sync_level,
  input wire logic [NUM_TX-1:0] sync_disable,
  input wire logic [NUM_TX-1:0] pass_level,
  input wire logic [NUM_TX-1:0] pass_err_evt,
  // results
  input wire logic [7:0]        rd_data_ff,
  input wire logic [NUM_TX-1:0] tx_irq_ff
);
  logic sel0, rd_sts0, we_en0, quiet0;
  assign sel0    = port_select == 8'h00;
  assign rd_sts0 = reg_rd && reg_addr == 8'h37 && sel0;
  assign we_en0  = reg_wr && reg_addr == 8'h36 && sel0;
  // low levels, so no edge can set a flag between the two reads
  assign quiet0  = !(sync_err_evt[0] | pass_err_evt[0] | pass_level[0] | sync_level[0]);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // sequences and properties
  sequence s_two_reads;
    rd_sts0 && quiet0 ##1 quiet0 ##1 rd_sts0 && quiet0;
  endsequence
  sequence s_enable_then_err;
    we_en0 && reg_wdata[1] ##1 !reg_wr ##1 pass_err_evt[0] && !reg_wr;
  endsequence
  // a clearing read or rx clear in between may legally remove the flag
  property p_sets(ev, int b);
    ev ##1 !rd_sts0 && !rx_irq_clr[0] ##1 rd_sts0 |=> rd_data_ff[b];
  endproperty
  // ==========================================================================
  // assertions
  a_rsvd_read_zero: assert property (
    reg_rd && reg_addr inside {[8'h38:8'h3F]} |=> rd_data_ff == 8'h00) else $error("rsvd");
  a_bad_select_zero: assert property (
    reg_rd && port_select >= NUM_TX |=> rd_data_ff == 8'h00) else $error("select");
  a_rx_flag_set: assert property (p_sets(rx_irq_evt[0], 4)) else $error("rx flag");
  a_sync_err_kept: assert property (
    p_sets(sync_err_evt[0] && rd_sts0, 3)) else $error("sync err flag");
  a_sync_flag_set: assert property (
    p_sets($rose(sync_level[0]) && !sync_disable[0], 2)) else $error("sync flag");
  a_clear_on_read: assert property (
    s_two_reads |=> rd_data_ff[3:0] == 4'h0) else $error("no clear");
  a_irq_drops: assert property (
    we_en0 && reg_wdata[4:0] == 5'h00 |=> !tx_irq_ff[0]) else $error("irq stuck");
  a_irq_raised: assert property (s_enable_then_err |=> tx_irq_ff[0]) else $error("irq");
endmodule : ctiu_sva

bind ctiu_top ctiu_sva #(.NUM_TX(NUM_TX)) u_sva (.sys_clk, .rst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .port_select, .rx_irq_evt, .rx_irq_clr, .sync_err_evt, .sync_level,
  .sync_disable, .pass_level, .pass_err_evt, .rd_data_ff, .tx_irq_ff);

/* File: dv/tb_csi_tx_port_interrupt_unit.sv */
// self-checking bench for the tx port interrupt unit, port 0 mostly
// assumes ctiu_top with two tx ports and the bound checker
`timescale 1ns/1ns
module tb_csi_tx_port_interrupt_unit;
  import ctiu_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_valid_ff;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port_select = 8'h00, rd_data_ff;
  logic [1:0] rx_irq_evt = 2'h0, rx_irq_clr = 2'h0, sync_err_evt = 2'h0, pass_err_evt = 2'h0;
  logic [1:0] sync_level = 2'h0, sync_disable = 2'h0, pass_level = 2'h0, tx_irq_ff;
  int         miscompares = 0, comparisons = 0;
  ctiu_top #(.NUM_TX(2)) uut (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .port_select, .rx_irq_evt, .rx_irq_clr, .sync_err_evt, .sync_level, .sync_disable,
    .pass_level, .pass_err_evt, .rd_data_ff, .rd_valid_ff, .tx_irq_ff);
  always #4 sys_clk = ~sys_clk;
  // ==========================================================================
  // access tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 check(rd_data_ff, e);
    check({7'h00, rd_valid_ff}, 8'h01);
  endtask : rdc
  // one cycle of pulses, levels rise with them and fall right after
  task automatic evt(input logic [4:0] m);
    @(posedge sys_clk);
    {rx_irq_evt[0], sync_err_evt[0], sync_level[0], pass_err_evt[0], pass_level[0]} <= m;
    @(posedge sys_clk);
    {rx_irq_evt[0], sync_err_evt[0], sync_level[0], pass_err_evt[0], pass_level[0]} <= 5'h00;
    #1;
  endtask : evt
  // ==========================================================================
  // scenarios
  task automatic t_events();
    rdc(IRQ_ENABLE_OFS, 8'h00);
    rdc(IRQ_STATUS_OFS, 8'h00);
    for (int b = 0; b < 5; b++) begin
      wr(IRQ_ENABLE_OFS, 8'h01 << b);
      evt(5'h01 << b);
      check({7'h00, tx_irq_ff[0]}, 8'h01);
      rdc(IRQ_STATUS_OFS, 8'h01 << b);
      rdc(IRQ_STATUS_OFS, (b == 4) ? 8'h10 : 8'h00);
      check({7'h00, tx_irq_ff[0]}, {7'h00, b == 4});
    end
    @(posedge sys_clk);
    rx_irq_clr <= 2'b01;
    @(posedge sys_clk);
    rx_irq_clr <= 2'b00;
    rdc(IRQ_STATUS_OFS, 8'h00);
    wr(IRQ_ENABLE_OFS, 8'h00);
    evt(5'h0F);
    check({7'h00, tx_irq_ff[0]}, 8'h00);
    rdc(IRQ_STATUS_OFS, 8'h0F);
  endtask : t_events
  task automatic t_coincide();
    @(posedge sys_clk);
    sync_err_evt <= 2'b01;
    reg_rd       <= 1'b1;
    reg_addr     <= IRQ_STATUS_OFS;
    @(posedge sys_clk);
    sync_err_evt <= 2'b00;
    reg_rd       <= 1'b0;
    #1 check(rd_data_ff, 8'h00);
    rdc(IRQ_STATUS_OFS, 8'h08);
  endtask : t_coincide
  task automatic t_live_and_select();
    @(posedge sys_clk);
    sync_disable <= 2'b01;
    sync_level   <= 2'b01;
    rdc(PORT_STATUS_OFS, 8'h00);
    rdc(IRQ_STATUS_OFS, 8'h00);
    @(posedge sys_clk);
    sync_disable <= 2'b00;
    rdc(PORT_STATUS_OFS, 8'h02);
    rdc(IRQ_STATUS_OFS, 8'h04);
    wr(IRQ_ENABLE_OFS, 8'hF5);
    for (int a = 8'h38; a <= 8'h3F; a++) begin
      wr(a[7:0], 8'hFF);
      rdc(a[7:0], 8'h00);
    end
    rdc(IRQ_ENABLE_OFS, 8'h15);
    @(posedge sys_clk);
    port_select <= 8'h01;
    rdc(IRQ_ENABLE_OFS, 8'h00);
    @(posedge sys_clk);
    port_select <= 8'h02;
    wr(IRQ_ENABLE_OFS, 8'hFF);
    rdc(IRQ_ENABLE_OFS, 8'h00);
    @(posedge sys_clk);
    port_select <= 8'h00;
    rdc(IRQ_ENABLE_OFS, 8'h15);
  endtask : t_live_and_select
  // second tx port on its own, port 0 must stay untouched
  task automatic t_port_one();
    @(posedge sys_clk);
    port_select <= 8'h01;
    wr(IRQ_ENABLE_OFS, 8'h01);
    @(posedge sys_clk);
    pass_level <= 2'b10;
    @(posedge sys_clk);
    #1 check({6'h00, tx_irq_ff}, 8'h02);
    rdc(PORT_STATUS_OFS, 8'h11);
    rdc(IRQ_STATUS_OFS, 8'h01);
    check({6'h00, tx_irq_ff}, 8'h00);
    @(posedge sys_clk);
    port_select <= 8'h00;
    rdc(IRQ_STATUS_OFS, 8'h00);
  endtask : t_port_one
  // ==========================================================================
  // run control
  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_events();
    t_coincide();
    t_live_and_select();
    t_port_one();
    complete_run();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_csi_tx_port_interrupt_unit
